/* common/scu_consts.vh */
// constants for the sensor command and status unit
`ifndef SCU_CONSTS_VH
`define SCU_CONSTS_VH

`define SCU_CLK_MHZ        40
`define SCU_PIN_MIN_NS     350
`define SCU_PIN_MIN_CYC    ((`SCU_PIN_MIN_NS * `SCU_CLK_MHZ + 999) / 1000)
`define SCU_RST_BUSY_NS    1000
`define SCU_RST_BUSY_CYC   ((`SCU_RST_BUSY_NS * `SCU_CLK_MHZ) / 1000)

`define SCU_CMD_ART        16'h30a2
`define SCU_CMD_HEAT_ON    16'h306d
`define SCU_CMD_HEAT_OFF   16'h3066
`define SCU_CMD_STAT_RD    16'hf32d
`define SCU_CMD_STAT_CLR   16'h3041
`define SCU_GC_ADDR        8'h00
`define SCU_GC_RESET       8'h06

`define SCU_CRC_POLY       8'h31
`define SCU_CRC_INIT       8'hff
`define SCU_CRC_XOROUT     8'h00

`define SCU_ST_ALERT       15
`define SCU_ST_HEATER      13
`define SCU_ST_RH_ALERT    11
`define SCU_ST_T_ALERT     10
`define SCU_ST_RESET       4
`define SCU_ST_CMD_ERR     1
`define SCU_ST_WCRC_ERR    0

`endif

/* hw/scu_command_status.v */
// i2c command interpreter, status word and crc of the sensor
`timescale 1ns/100ps
`include "scu_consts.vh"

// Function
// - periodic readout starts with the fetch command, then a read header
// - read header after fetch with no waiting result is nacked; transfer ends
// - command 0x30a2 starts periodic acquisition with accelerated response
// - accelerated mode is started and read exactly like other periodic modes
// - soft reset, reset pin, power-up or brownout cause a system reset
// - commands are ignored while a reset is in progress
// - soft reset restarts the controller and reloads calibration
// - calibration is reloaded before every measurement
// - reset pin active low; low at least 350 ns gives full reset
// - general call 0x00 then 0x06 resets like the pin, only when not busy
// - heater switched on by 0x306d and off by 0x3066
// - heater off after reset; status bit 13 shows heater state
// - command 0xf32d returns status word plus crc on next read
// - clear-status 0x3041 zeroes status bits 15, 11, 10 and 4
// - bit 15 set while any alert pending; bit 11 humidity, bit 10 temperature
// - bit 4 set after any reset, held until clear-status
// - bit 1 set when last command invalid, cleared on success
// - bit 0 reflects checksum of last write data word
// - crc-8 over two bytes, poly 0x31, init 0xff, no reflection
// - crc follows every 16-bit data word in both directions; the command word has none
// - sending stops as soon as the master does not acknowledge a byte
// - each received byte acknowledged by pulling sda low in ninth clock, unless busy, another address, or a read header with nothing to send
module scu_command_status #(
   parameter [6:0]  DEV_ADDR  = 7'h10,
   parameter [15:0] FETCH_CMD = 16'he000,
   parameter [15:0] SRST_CMD  = 16'h30a3
) (
   input  wire        i_clock,
   input  wire        i_reset_n,
   input  wire        i_scl,
   input  wire        i_sda,
   output reg         o_sda_out,
   output reg         o_sda_oe,
   input  wire        i_active_low_reset_pin_n,
   input  wire        i_brownout,
   input  wire        i_meas_begin,
   input  wire        i_meas_valid,
   input  wire [15:0] i_meas_temp,
   input  wire [15:0] i_meas_hum,
   input  wire        i_alert_rh,
   input  wire        i_alert_t,
   output reg         o_heater_on,
   output reg         o_periodic_on,
   output reg         o_art_on,
   output reg         o_reset_busy,
   output reg         o_calib_load,
   output reg  [15:0] o_condition_word
);
   localparam [2:0] ST_IDLE = 3'd0;
   localparam [2:0] ST_ADDR = 3'd1;
   localparam [2:0] ST_ACK  = 3'd2;
   localparam [2:0] ST_RX   = 3'd3;
   localparam [2:0] ST_TX   = 3'd4;
   localparam [2:0] ST_MACK = 3'd5;
   localparam [1:0] SRC_NONE  = 2'd0;
   localparam [1:0] SRC_FETCH = 2'd1;
   localparam [1:0] SRC_STAT  = 2'd2;
   localparam integer PIN_MIN_I = `SCU_PIN_MIN_CYC;
   localparam integer BUSY_I    = `SCU_RST_BUSY_CYC;
   localparam [3:0] PIN_MIN   = PIN_MIN_I[3:0];
   localparam [7:0] BUSY_CYC  = BUSY_I[7:0];

   // crc-8, msb first, no reflection
   function [7:0] crc8;
      input [15:0] d;
      integer      i;
      reg [7:0]    c;
      begin
         c = `SCU_CRC_INIT;
         for (i = 15; i >= 0; i = i - 1) begin
            if (c[7] ^ d[i])
               c = {c[6:0], 1'b0} ^ `SCU_CRC_POLY;
            else
               c = {c[6:0], 1'b0};
         end
         crc8 = c ^ `SCU_CRC_XOROUT;
      end
   endfunction

   function is_periodic;
      input [15:0] c;
      begin
         case (c)
            16'h2032, 16'h2024, 16'h202f, 16'h2130, 16'h2126, 16'h212d,
            16'h2236, 16'h2220, 16'h222b, 16'h2334, 16'h2322, 16'h2329,
            16'h2737, 16'h2721, 16'h272a: is_periodic = 1'b1;
            default: is_periodic = 1'b0;
         endcase
      end
   endfunction

   // two-flop synchronisers; only the second stage is read by logic
   reg [1:0]  scl_sync;
   reg [1:0]  sda_sync;
   reg [1:0]  pin_sync;
   reg [1:0]  bo_sync;
   reg        scl_d;
   reg        sda_d;
   reg        bo_d;
   reg [2:0]  state;
   reg [3:0]  bit_cnt;
   reg [7:0]  shreg;
   reg [2:0]  byte_idx;
   reg        is_gc;
   reg        is_read;
   reg [7:0]  cmd_msb;
   reg [15:0] rx_word;
   reg [15:0] tx_w0;
   reg [15:0] tx_w1;
   reg [2:0]  tx_len;
   reg [1:0]  rd_src;
   reg        rst_cmd;
   reg [3:0]  pin_cnt;
   reg [7:0]  busy_cnt;
   reg        data_rdy;
   reg [15:0] meas_t;
   reg [15:0] meas_h;
   reg        st_rh;
   reg        st_t;
   reg        st_reset;
   reg        st_cmd;
   reg        st_wcrc;
   reg [7:0]  tx_byte;

   wire scl_s  = scl_sync[1];
   wire sda_s  = sda_sync[1];
   wire scl_r  = scl_s & ~scl_d;
   wire scl_f  = ~scl_s & scl_d;
   wire start  = scl_s & scl_d & sda_d & ~sda_s;
   wire stop   = scl_s & scl_d & ~sda_d & sda_s;
   wire busy   = (busy_cnt != 8'h00);
   wire pin_ev = ~pin_sync[1] & (pin_cnt == PIN_MIN - 4'd1);
   wire bo_ev  = bo_sync[1] & ~bo_d;
   wire rst_ev = rst_cmd | pin_ev | bo_ev;
   wire [15:0] full_cmd = {cmd_msb, shreg};
   wire [15:0] status = {st_rh | st_t, 1'b0, o_heater_on, 1'b0, st_rh, st_t, 5'h00,
                         st_reset, 2'h0, st_cmd, st_wcrc};

   always @* begin
      if (byte_idx >= tx_len)
         tx_byte = 8'hff;
      else begin
         case (byte_idx)
            3'd0: tx_byte = tx_w0[15:8];
            3'd1: tx_byte = tx_w0[7:0];
            3'd2: tx_byte = crc8(tx_w0);
            3'd3: tx_byte = tx_w1[15:8];
            3'd4: tx_byte = tx_w1[7:0];
            3'd5: tx_byte = crc8(tx_w1);
            default: tx_byte = 8'hff;
         endcase
      end
   end

   always @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         pin_sync <= 2'h3;
         bo_sync  <= 2'h0;
         scl_d    <= 1'b1;
         sda_d    <= 1'b1;
         bo_d     <= 1'b0;
         state    <= ST_IDLE;
         bit_cnt  <= 4'h0;
         shreg    <= 8'h00;
         byte_idx <= 3'h0;
         is_gc    <= 1'b0;
         is_read  <= 1'b0;
         cmd_msb  <= 8'h00;
         rx_word  <= 16'h0000;
         tx_w0    <= 16'h0000;
         tx_w1    <= 16'h0000;
         tx_len   <= 3'h0;
         rd_src   <= SRC_NONE;
         rst_cmd  <= 1'b0;
         pin_cnt  <= 4'h0;
         busy_cnt <= BUSY_CYC;
         data_rdy <= 1'b0;
         meas_t   <= 16'h0000;
         meas_h   <= 16'h0000;
         st_rh    <= 1'b0;
         st_t     <= 1'b0;
         st_reset <= 1'b1; // power-up counts as a reset
         st_cmd   <= 1'b0;
         st_wcrc  <= 1'b0;
         o_sda_out        <= 1'b0;
         o_sda_oe         <= 1'b0;
         o_heater_on      <= 1'b0;
         o_periodic_on    <= 1'b0;
         o_art_on         <= 1'b0;
         o_reset_busy     <= 1'b1;
         o_calib_load     <= 1'b1;
         o_condition_word <= 16'h0000;
      end else begin
         scl_sync <= {scl_sync[0], i_scl};
         sda_sync <= {sda_sync[0], i_sda};
         pin_sync <= {pin_sync[0], i_active_low_reset_pin_n};
         bo_sync  <= {bo_sync[0], i_brownout};
         scl_d    <= scl_s;
         sda_d    <= sda_s;
         bo_d     <= bo_sync[1];
         rst_cmd  <= 1'b0;
         o_sda_out        <= 1'b0;
         o_calib_load     <= i_meas_begin;
         o_condition_word <= status;
         if (pin_sync[1])
            pin_cnt <= 4'h0;
         else if (pin_cnt != PIN_MIN)
            pin_cnt <= pin_cnt + 4'd1;
         if (busy)
            busy_cnt <= busy_cnt - 8'd1;

         if (start) begin
            state    <= ST_ADDR;
            bit_cnt  <= 4'h0;
            byte_idx <= 3'h0;
            o_sda_oe <= 1'b0;
         end else if (stop) begin
            state    <= ST_IDLE;
            o_sda_oe <= 1'b0;
         end else begin
            case (state)
               ST_ADDR, ST_RX: begin
                  if (scl_r && bit_cnt != 4'd8) begin
                     shreg   <= {shreg[6:0], sda_s};
                     bit_cnt <= bit_cnt + 4'd1;
                  end else if (scl_f && bit_cnt == 4'd8) begin
                     bit_cnt <= 4'h0;
                     state   <= ST_IDLE;
                     if (busy) begin
                        state <= ST_IDLE; // no ack during reset
                     end else if (state == ST_ADDR) begin
                        is_gc   <= (shreg == `SCU_GC_ADDR);
                        is_read <= shreg[0];
                        if (shreg == `SCU_GC_ADDR || shreg == {DEV_ADDR, 1'b0}) begin
                           o_sda_oe <= 1'b1;
                           state    <= ST_ACK;
                        end else if (shreg == {DEV_ADDR, 1'b1}) begin
                           rd_src <= SRC_NONE;
                           if (rd_src == SRC_STAT) begin
                              o_sda_oe <= 1'b1;
                              state    <= ST_ACK;
                              tx_w0    <= status;
                              tx_len   <= 3'd3;
                           end else if (rd_src == SRC_FETCH && data_rdy) begin
                              o_sda_oe <= 1'b1;
                              state    <= ST_ACK;
                              tx_w0    <= meas_t;
                              tx_w1    <= meas_h;
                              tx_len   <= 3'd6;
                              data_rdy <= 1'b0;
                           end
                           // otherwise the header is left unacknowledged
                        end
                     end else begin
                        o_sda_oe <= 1'b1;
                        state    <= ST_ACK;
                        if (byte_idx != 3'd7)
                           byte_idx <= byte_idx + 3'd1;
                        if (is_gc) begin
                           if (byte_idx == 3'd0 && shreg == `SCU_GC_RESET)
                              rst_cmd <= 1'b1;
                        end else begin
                           case (byte_idx)
                              3'd0: cmd_msb <= shreg;
                              3'd1: begin
                                 st_cmd <= 1'b0;
                                 rd_src <= SRC_NONE;
                                 if (full_cmd == FETCH_CMD)
                                    rd_src <= SRC_FETCH;
                                 else if (full_cmd == `SCU_CMD_STAT_RD)
                                    rd_src <= SRC_STAT;
                                 else if (full_cmd == `SCU_CMD_STAT_CLR) begin
                                    st_rh    <= 1'b0;
                                    st_t     <= 1'b0;
                                    st_reset <= 1'b0;
                                 end else if (full_cmd == `SCU_CMD_HEAT_ON)
                                    o_heater_on <= 1'b1;
                                 else if (full_cmd == `SCU_CMD_HEAT_OFF)
                                    o_heater_on <= 1'b0;
                                 else if (full_cmd == `SCU_CMD_ART) begin
                                    o_periodic_on <= 1'b1;
                                    o_art_on      <= 1'b1;
                                    data_rdy      <= 1'b0;
                                 end else if (is_periodic(full_cmd)) begin
                                    o_periodic_on <= 1'b1;
                                    o_art_on      <= 1'b0;
                                    data_rdy      <= 1'b0;
                                 end else if (full_cmd == SRST_CMD)
                                    rst_cmd <= 1'b1;
                                 else
                                    st_cmd <= 1'b1;
                              end
                              3'd2: rx_word[15:8] <= shreg;
                              3'd3: rx_word[7:0] <= shreg;
                              3'd4: st_wcrc <= (crc8(rx_word) != shreg);
                              default: st_wcrc <= st_wcrc;
                           endcase
                        end
                     end
                  end
               end
               ST_ACK: begin
                  if (scl_f) begin
                     if (is_read) begin
                        shreg    <= tx_byte;
                        o_sda_oe <= ~tx_byte[7];
                        bit_cnt  <= 4'd1;
                        state    <= ST_TX;
                     end else begin
                        o_sda_oe <= 1'b0;
                        bit_cnt  <= 4'h0;
                        state    <= ST_RX;
                     end
                  end
               end
               ST_TX: begin
                  if (scl_f) begin
                     if (bit_cnt == 4'd8) begin
                        o_sda_oe <= 1'b0;
                        state    <= ST_MACK;
                     end else begin
                        o_sda_oe <= ~shreg[6];
                        shreg    <= {shreg[6:0], 1'b0};
                        bit_cnt  <= bit_cnt + 4'd1;
                     end
                  end
               end
               ST_MACK: begin
                  if (scl_r) begin
                     if (sda_s)
                        state <= ST_IDLE;
                     else begin
                        state <= ST_ACK;
                        if (byte_idx != 3'd7)
                           byte_idx <= byte_idx + 3'd1;
                     end
                  end
               end
               default: state <= ST_IDLE;
            endcase
         end

         // new results and alerts win over a clear in the same cycle
         if (i_meas_valid && o_periodic_on) begin
            meas_t   <= i_meas_temp;
            meas_h   <= i_meas_hum;
            data_rdy <= 1'b1;
         end
         if (i_alert_rh)
            st_rh <= 1'b1;
         if (i_alert_t)
            st_t <= 1'b1;

         if (rst_ev) begin
            busy_cnt      <= BUSY_CYC;
            o_heater_on   <= 1'b0;
            o_periodic_on <= 1'b0;
            o_art_on      <= 1'b0;
            data_rdy      <= 1'b0;
            rd_src        <= SRC_NONE;
            st_rh         <= 1'b0;
            st_t          <= 1'b0;
            st_cmd        <= 1'b0;
            st_wcrc       <= 1'b0;
            st_reset      <= 1'b1;
            o_calib_load  <= 1'b1;
         end
         o_reset_busy <= busy | rst_ev;
      end
   end
endmodule // scu_command_status

/* tb/scu_command_status_properties.sv */
// port-level checks of the sensor command and status unit
`timescale 1ns/100ps
module scu_command_status_properties (
   input wire        i_clock,
   input wire        i_reset_n,
   input wire        i_active_low_reset_pin_n,
   input wire        i_brownout,
   input wire        i_meas_begin,
   input wire        i_alert_rh,
   input wire        o_sda_oe,
   input wire        o_heater_on,
   input wire        o_reset_busy,
   input wire        o_calib_load,
   input wire [15:0] o_condition_word
);
   default clocking @(posedge i_clock);
   endclocking
   default disable iff (!i_reset_n);

   chk_calib_after_begin: assert property (
      i_meas_begin |=> o_calib_load) else $error("no calibration reload");
   chk_heater_off_busy: assert property (
      o_reset_busy |-> !o_heater_on) else $error("heater on during reset");
   chk_heater_bit: assert property (
      $changed(o_heater_on) |-> ##[0:2] o_condition_word[13] == o_heater_on)
      else $error("heater bit wrong");
   chk_alert_sum: assert property (
      o_condition_word[15] == (o_condition_word[11] | o_condition_word[10]))
      else $error("alert summary wrong");
   chk_alert_sets: assert property (
      i_alert_rh && !o_reset_busy |-> ##[1:3] o_condition_word[11])
      else $error("humidity alert not flagged");
   chk_reserved_zero: assert property (
      (o_condition_word & 16'h53ec) == 16'h0000) else $error("reserved bit set");
   chk_reset_flag: assert property (
      $fell(o_reset_busy) |-> o_condition_word[4]) else $error("reset flag clear");
   chk_busy_no_ack: assert property (
      $rose(o_sda_oe) |-> !$past(o_reset_busy)) else $error("ack while busy");
   chk_pin_reset: assert property (
      $fell(i_active_low_reset_pin_n) ##1 !i_active_low_reset_pin_n[*8]
      ##1 !i_active_low_reset_pin_n[*8] |-> ##[0:6] o_reset_busy)
      else $error("pin reset missed");
   chk_brownout_reset: assert property (
      $rose(i_brownout) |-> ##[1:6] o_reset_busy) else $error("brownout missed");
endmodule // scu_command_status_properties

bind scu_command_status scu_command_status_properties u_chk (
   .i_clock(i_clock),
   .i_reset_n(i_reset_n),
   .i_active_low_reset_pin_n(i_active_low_reset_pin_n),
   .i_brownout(i_brownout),
   .i_meas_begin(i_meas_begin),
   .i_alert_rh(i_alert_rh),
   .o_sda_oe(o_sda_oe),
   .o_heater_on(o_heater_on),
   .o_reset_busy(o_reset_busy),
   .o_calib_load(o_calib_load),
   .o_condition_word(o_condition_word)
);

/* tb/scu_i2c_master.sv */
// bus master model driving scl and the low side of sda
`timescale 1ns/100ps
module scu_i2c_master (
   input  wire       i_clock,
   input  wire       i_sda,
   output reg        o_scl,
   output reg        o_sda_low,
   output reg        o_got,
   output reg  [8:0] o_got_byte
);
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
      o_got = 1'b0;
      o_got_byte = 9'h000;
   end
   task tick(input integer n);
      repeat (n) @(posedge i_clock);
   endtask
   // 8 clocks a bit: data set mid-low, sampled mid-high, clear of sensor delay
   task bitx(input b, output s);
      o_scl <= 1'b0;
      tick(2);
      o_sda_low <= ~b;
      tick(2);
      o_scl <= 1'b1;
      tick(2);
      s = i_sda;
      tick(2);
   endtask
   task start;
      o_scl <= 1'b0;
      tick(2);
      o_sda_low <= 1'b0;
      tick(2);
      o_scl <= 1'b1;
      tick(2);
      o_sda_low <= 1'b1;
      tick(2);
   endtask
   task stop;
      o_scl <= 1'b0;
      tick(2);
      o_sda_low <= 1'b1;
      tick(2);
      o_scl <= 1'b1;
      tick(2);
      o_sda_low <= 1'b0;
      tick(4);
   endtask
   // nb is the ninth bit: 1 releases sda, 0 acks a read byte
   task xfer(input [7:0] d, input nb);
      reg [7:0] r;
      reg       a;
      integer   i;
      for (i = 7; i >= 0; i = i - 1) bitx(d[i], r[i]);
      bitx(nb, a);
      o_got_byte <= {r, ~a};
      o_got <= 1'b1;
      @(posedge i_clock);
      o_got <= 1'b0;
   endtask
endmodule // scu_i2c_master

/* tb/scu_command_status_tb.sv */
// self-checking bench of the sensor command and status unit
`timescale 1ns/100ps
`include "scu_consts.vh"
module scu_command_status_tb;
   localparam [6:0]  ADDR = 7'h10;
   localparam [15:0] FETCH = 16'he000;
   localparam [15:0] SRST = 16'h30a3;
   reg         clk, rst_n, pin_n, brown, mbeg, mval, a_rh, a_t;
   reg  [15:0] temp, hum;
   wire        scl, m_low, oe, sout, heat, per, art, busy, cal, got, sda;
   wire [15:0] cw;
   wire [8:0]  gb;
   reg  [8:0]  exp_q[$];
   integer     error_cnt, n_checks, seed, i;
   assign sda = (m_low | (oe & ~sout)) ? 1'b0 : 1'b1;

   scu_command_status #(.DEV_ADDR(ADDR), .FETCH_CMD(FETCH), .SRST_CMD(SRST))
   u_scu_command_status (.i_clock(clk), .i_reset_n(rst_n), .i_scl(scl), .i_sda(sda),
      .o_sda_out(sout), .o_sda_oe(oe), .i_active_low_reset_pin_n(pin_n),
      .i_brownout(brown), .i_meas_begin(mbeg), .i_meas_valid(mval), .i_meas_temp(temp),
      .i_meas_hum(hum), .i_alert_rh(a_rh), .i_alert_t(a_t), .o_heater_on(heat),
      .o_periodic_on(per), .o_art_on(art), .o_reset_busy(busy), .o_calib_load(cal),
      .o_condition_word(cw));
   scu_i2c_master u_scu_i2c_master (.i_clock(clk), .i_sda(sda), .o_scl(scl),
      .o_sda_low(m_low), .o_got(got), .o_got_byte(gb));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task check(input [15:0] seen, input [15:0] expv);
      n_checks = n_checks + 1;
      if (seen !== expv) begin
         error_cnt = error_cnt + 1;
         $display("Error at %0t: saw %h expected %h", $time, seen, expv);
      end
   endtask
   function [7:0] crc8(input [15:0] w);
      integer   k;
      reg [7:0] c;
      begin
         c = `SCU_CRC_INIT;
         for (k = 15; k >= 0; k = k - 1)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ w[k]) ? `SCU_CRC_POLY : 8'h00);
         crc8 = c;
      end
   endfunction
   task wb(input [7:0] d, input ak);
      exp_q.push_back({d, ak});
      u_scu_i2c_master.xfer(d, 1'b1);
   endtask
   task rb(input [7:0] d, input ak);
      exp_q.push_back({d, ak});
      u_scu_i2c_master.xfer(8'hff, ~ak);
   endtask
   task cmd(input [15:0] c);
      u_scu_i2c_master.start;
      wb({ADDR, 1'b0}, 1'b1);
      wb(c[15:8], 1'b1);
      wb(c[7:0], 1'b1);
      u_scu_i2c_master.stop;
   endtask
   // command followed by one data word and its checksum byte
   task cmdw(input [15:0] c, input [23:0] d);
      u_scu_i2c_master.start;
      wb({ADDR, 1'b0}, 1'b1);
      wb(c[15:8], 1'b1);
      wb(c[7:0], 1'b1);
      wb(d[23:16], 1'b1);
      wb(d[15:8], 1'b1);
      wb(d[7:0], 1'b1);
      u_scu_i2c_master.stop;
   endtask
   // command, then read header acked when n is nonzero, then n bytes
   task rd(input [15:0] c, input [2:0] n, input [47:0] b);
      integer k;
      cmd(c);
      u_scu_i2c_master.start;
      wb({ADDR, 1'b1}, n != 0);
      for (k = 0; k < n; k = k + 1) rb(b[47 - 8 * k -: 8], k != n - 1);
      u_scu_i2c_master.stop;
   endtask
   task idle;
      integer k;
      for (k = 0; k < 200 && busy !== 1'b0; k = k + 1) @(posedge clk);
      check(busy, 1'b0);
   endtask
   task results;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   always @(posedge clk)
      if (got === 1'b1) check(gb, exp_q.pop_front());

   initial begin
      #(60000 * 25);
      error_cnt = error_cnt + 1;
      results;
   end

   initial begin
      seed = 32'h6a3e;
      error_cnt = 0;
      n_checks = 0;
      {rst_n, brown, mbeg, mval, a_rh, a_t} = 6'h00;
      pin_n = 1'b1;
      {temp, hum} = 32'h0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      idle;
      rd(`SCU_CMD_STAT_RD, 3, {16'h0010, crc8(16'h0010), 24'h0});
      cmd(`SCU_CMD_HEAT_ON);
      check(heat, 1'b1);
      a_rh <= 1'b1;
      @(posedge clk);
      {a_rh, a_t} <= 2'b01;
      @(posedge clk);
      a_t <= 1'b0;
      rd(`SCU_CMD_STAT_RD, 3, {16'hac10, crc8(16'hac10), 24'h0});
      cmd(`SCU_CMD_STAT_CLR);
      check(cw, 16'h2000);
      cmd(`SCU_CMD_HEAT_OFF);
      cmd(16'h1234);
      check(cw, 16'h0002);
      cmdw(`SCU_CMD_HEAT_OFF, 24'hbeef00);
      check(cw, 16'h0001);
      cmdw(`SCU_CMD_HEAT_OFF, 24'hbeef92);
      check(cw, 16'h0000);
      rd(FETCH, 0, 48'h0);
      check(cw, 16'h0000);
      cmd(`SCU_CMD_ART);
      check({per, art}, 2'b11);
      for (i = 0; i < 3; i = i + 1) begin
         {temp, hum} <= $random(seed);
         mbeg <= 1'b1;
         @(posedge clk);
         mbeg <= 1'b0;
         mval <= 1'b1;
         #1 check(cal, 1'b1);
         @(posedge clk);
         mval <= 1'b0;
         rd(FETCH, (i == 2) ? 1 : 6, {temp, crc8(temp), hum, crc8(hum)});
         check(oe, 1'b0);
         rd(FETCH, 0, 48'h0);
      end
      cmd(`SCU_CMD_HEAT_ON);
      u_scu_i2c_master.start;
      wb({ADDR, 1'b0}, 1'b1);
      wb(SRST[15:8], 1'b1);
      wb(SRST[7:0], 1'b1);
      u_scu_i2c_master.stop;
      check({busy, heat, per}, 3'b100);
      idle;
      check(cw, 16'h0010);
      pin_n <= 1'b0;
      repeat (20) @(posedge clk);
      pin_n <= 1'b1;
      repeat (4) @(posedge clk);
      check(busy, 1'b1);
      idle;
      u_scu_i2c_master.start;
      wb(`SCU_GC_ADDR, 1'b1);
      wb(`SCU_GC_RESET, 1'b1);
      u_scu_i2c_master.stop;
      check(busy, 1'b1);
      idle;
      brown <= 1'b1;
      repeat (4) @(posedge clk);
      brown <= 1'b0;
      repeat (4) @(posedge clk);
      check(busy, 1'b1);
      idle;
      check(16'(exp_q.size()), 16'h0000);
      results;
   end
endmodule // scu_command_status_tb
